// >>> bw_bitmap_store.sv
`timescale 1ns/1ns
// bitmap words for both spaces, all instances and partitions
module bw_bitmap_store (
	input  wire logic                           clk_sys,
	input  wire logic                           wr_en,
	input  wire logic [bw_cfg_pkg::PBM_IDX_W-1:0] wr_idx,
	input  wire logic [bw_cfg_pkg::DATA_W-1:0]    wr_data,
	input  wire logic [bw_cfg_pkg::PBM_IDX_W-1:0] rd_idx,
	output logic      [bw_cfg_pkg::DATA_W-1:0]    rd_data,
	input  wire logic [bw_cfg_pkg::PBM_IDX_W-1:0] lk_idx,
	output logic      [bw_cfg_pkg::DATA_W-1:0]    lk_data
);
	// contents are not reset; software configures before use
	logic [bw_cfg_pkg::DATA_W-1:0] mem [bw_cfg_pkg::NUM_PBM];

	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem[wr_idx] <= wr_data;
		end
	end

	assign rd_data = mem[rd_idx];
	assign lk_data = mem[lk_idx];
endmodule : bw_bitmap_store

// >>> bw_cfg_pkg.sv
package bw_cfg_pkg;
	localparam int PART_W      = 2;
	localparam int NUM_PART    = 4;
	localparam int INST_W      = 1;
	localparam int NUM_INST    = 2;
	localparam int SEL_PART_W  = 16;
	localparam int SEL_INST_W  = 4;
	localparam int ADDR_W      = 16;
	localparam int DATA_W      = 32;
	localparam int FRAC_W      = 16;
	localparam int WORD_IDX_W  = 7;
	localparam int NUM_WORDS   = 128;
	localparam int BWA_W       = 6;
	localparam int PBM_WD_W    = 13;
	localparam int PORTION_W   = 12;
	localparam int BIT_IDX_W   = 5;
	localparam int WORD_LSB    = 2;
	localparam int MIN_IDX_W   = 1 + INST_W + PART_W;
	localparam int NUM_MIN     = 2 * NUM_INST * NUM_PART;
	localparam int PBM_IDX_W   = MIN_IDX_W + WORD_IDX_W;
	localparam int NUM_PBM     = NUM_MIN * NUM_WORDS;

	localparam logic [ADDR_W-1:0] MIN_OFFSET = 16'h0200;
	localparam logic [ADDR_W-1:0] PBM_BASE   = 16'h2000;
	localparam logic [ADDR_W-1:0] PBM_LAST   = 16'h21FC;
	localparam logic [FRAC_W-1:0] FRAC_ONES  = 16'hFFFF;
	localparam logic [DATA_W-1:0] WORD_ONES  = 32'hFFFF_FFFF;
	localparam logic [DATA_W-1:0] WORD_ZERO  = 32'h0000_0000;
	localparam logic [DATA_W-1:0] WORD_ONE   = 32'h0000_0001;
	localparam logic [FRAC_W-1:0] RSVD_ZERO  = 16'h0000;
	localparam logic [BWA_W-1:0]  FRAC_FULL  = 6'h10;
	localparam logic              SPACE_NS   = 1'b0;
	localparam logic              SPACE_S    = 1'b1;
endpackage : bw_cfg_pkg

// >>> bw_min_arbiter.sv
`timescale 1ns/1ns
// grants one requester per cycle, below-minimum ones first
module bw_min_arbiter (
	input  wire logic                                          clk_sys,
	input  wire logic                                          rst_n,
	input  wire logic [bw_cfg_pkg::NUM_PART-1:0]                 req,
	input  wire logic [bw_cfg_pkg::NUM_PART*bw_cfg_pkg::FRAC_W-1:0] usage,
	input  wire logic [bw_cfg_pkg::NUM_PART*bw_cfg_pkg::FRAC_W-1:0] minv,
	output logic      [bw_cfg_pkg::NUM_PART-1:0]                 grant
);
	typedef struct packed {
		logic [bw_cfg_pkg::NUM_PART-1:0] grant;
	} arb_state_t;

	arb_state_t                      st_q;
	arb_state_t                      st_d;
	logic [bw_cfg_pkg::NUM_PART-1:0] below;

	genvar g;
	generate
		for (g = 0; g < bw_cfg_pkg::NUM_PART; g++) begin : g_cmp
			// both unsigned fractions share one binary point
			assign below[g] = req[g] &&
				(usage[g*bw_cfg_pkg::FRAC_W +: bw_cfg_pkg::FRAC_W] <
				 minv[g*bw_cfg_pkg::FRAC_W +: bw_cfg_pkg::FRAC_W]);
		end
	endgenerate

	always_comb begin
		logic [bw_cfg_pkg::NUM_PART-1:0] pool;
		logic                            found;
		pool  = (|below) ? below : req;
		found = 1'b0;
		st_d  = st_q;
		st_d.grant = '0;
		for (int i = 0; i < bw_cfg_pkg::NUM_PART; i++) begin
			if (pool[i] && !found) begin
				st_d.grant[i] = 1'b1;
				found         = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign grant = st_q.grant;

	arb_priority_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(|grant) |-> ((grant & $past(below)) != '0) || ($past(below) == '0))
		else $error("grant given past a below-minimum requester");

	arb_onehot_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(rst_n) && $past(|req) |-> $onehot(grant))
		else $error("grant not one-hot after a request");
endmodule : bw_min_arbiter

// >>> bw_min_portion_partition_cfg.sv
`timescale 1ns/1ns
module bw_min_portion_partition_cfg (
	input  wire logic                                   clk_sys,
	input  wire logic                                   rst_n,
	input  wire logic                                   reg_req,
	input  wire logic                                   reg_we,
	input  wire logic                                   reg_secure,
	input  wire logic [bw_cfg_pkg::ADDR_W-1:0]            reg_addr,
	input  wire logic [bw_cfg_pkg::DATA_W-1:0]            reg_wdata,
	output logic                                        reg_ack,
	output logic      [bw_cfg_pkg::DATA_W-1:0]            reg_rdata,
	input  wire logic [bw_cfg_pkg::SEL_PART_W-1:0]        sel_part_s,
	input  wire logic [bw_cfg_pkg::SEL_INST_W-1:0]        sel_inst_s,
	input  wire logic                                   sel_internal_s,
	input  wire logic [bw_cfg_pkg::SEL_PART_W-1:0]        sel_part_ns,
	input  wire logic [bw_cfg_pkg::SEL_INST_W-1:0]        sel_inst_ns,
	input  wire logic                                   sel_internal_ns,
	input  wire logic                                   feature_present,
	input  wire logic                                   bw_partitioning_flag,
	input  wire logic                                   min_capability_flag,
	input  wire logic                                   bitmap_capability_flag,
	input  wire logic                                   instance_select_capability,
	input  wire logic                                   narrowing_implemented,
	input  wire logic [bw_cfg_pkg::BWA_W-1:0]             alloc_fraction_width,
	input  wire logic [bw_cfg_pkg::PBM_WD_W-1:0]          portion_bitmap_width,
	input  wire logic                                   arb_secure,
	input  wire logic [bw_cfg_pkg::INST_W-1:0]            arb_instance,
	input  wire logic [bw_cfg_pkg::NUM_PART-1:0]          arb_req,
	input  wire logic [bw_cfg_pkg::NUM_PART*bw_cfg_pkg::FRAC_W-1:0] arb_usage,
	output logic      [bw_cfg_pkg::NUM_PART-1:0]          arb_grant,
	input  wire logic                                   lk_secure,
	input  wire logic [bw_cfg_pkg::INST_W-1:0]            lk_instance,
	input  wire logic [bw_cfg_pkg::PART_W-1:0]            lk_partition,
	input  wire logic [bw_cfg_pkg::PORTION_W-1:0]         lk_portion,
	output logic                                        lk_allowed
);
	typedef struct packed {
		logic                                   ack;
		logic [bw_cfg_pkg::DATA_W-1:0]            rdata;
		logic                                   allowed;
		logic [bw_cfg_pkg::NUM_MIN-1:0][bw_cfg_pkg::FRAC_W-1:0] min;
	} cfg_state_t;

	// implemented fraction bits sit at the top of the field
	function automatic logic [bw_cfg_pkg::FRAC_W-1:0] frac_mask(
		input logic [bw_cfg_pkg::BWA_W-1:0] w
	);
		if (w >= bw_cfg_pkg::FRAC_FULL) begin
			frac_mask = bw_cfg_pkg::FRAC_ONES;
		end else begin
			frac_mask = ~(bw_cfg_pkg::FRAC_ONES >> w);
		end
	endfunction : frac_mask

	function automatic logic [bw_cfg_pkg::DATA_W-1:0] word_mask(
		input logic [bw_cfg_pkg::WORD_IDX_W-1:0] n,
		input logic [bw_cfg_pkg::PBM_WD_W-1:0]   w
	);
		logic [bw_cfg_pkg::WORD_IDX_W-1:0] top;
		top = w[bw_cfg_pkg::PORTION_W-1:bw_cfg_pkg::BIT_IDX_W];
		if (w[bw_cfg_pkg::PORTION_W]) begin
			word_mask = bw_cfg_pkg::WORD_ONES;
		end else if (n < top) begin
			word_mask = bw_cfg_pkg::WORD_ONES;
		end else if (n == top) begin
			word_mask = (bw_cfg_pkg::WORD_ONE <<
				w[bw_cfg_pkg::BIT_IDX_W-1:0]) - bw_cfg_pkg::WORD_ONE;
		end else begin
			word_mask = bw_cfg_pkg::WORD_ZERO;
		end
	endfunction : word_mask

	cfg_state_t                              st_q;
	cfg_state_t                              st_d;
	logic [bw_cfg_pkg::SEL_PART_W-1:0]       sel_part;
	logic [bw_cfg_pkg::SEL_INST_W-1:0]       sel_inst;
	logic                                    sel_internal;
	logic [bw_cfg_pkg::INST_W-1:0]           inst_eff;
	logic                                    inst_ok;
	logic                                    sel_ok;
	logic                                    min_present;
	logic                                    pbm_present;
	logic                                    is_min;
	logic                                    is_pbm;
	logic [bw_cfg_pkg::MIN_IDX_W-1:0]        min_idx;
	logic [bw_cfg_pkg::WORD_IDX_W-1:0]       word_n;
	logic [bw_cfg_pkg::PBM_IDX_W-1:0]        pbm_idx;
	logic [bw_cfg_pkg::FRAC_W-1:0]           fmask;
	logic [bw_cfg_pkg::DATA_W-1:0]           wmask;
	logic                                    pbm_wr;
	logic [bw_cfg_pkg::DATA_W-1:0]           pbm_rd;
	logic [bw_cfg_pkg::PBM_IDX_W-1:0]        lk_idx;
	logic [bw_cfg_pkg::DATA_W-1:0]           lk_word;
	logic [bw_cfg_pkg::DATA_W-1:0]           lk_mask;
	logic [bw_cfg_pkg::NUM_PART*bw_cfg_pkg::FRAC_W-1:0] arb_min;

	// each space sees only its own selector
	assign sel_part     = reg_secure ? sel_part_s : sel_part_ns;
	assign sel_inst     = reg_secure ? sel_inst_s : sel_inst_ns;
	assign sel_internal = reg_secure ? sel_internal_s : sel_internal_ns;
	assign inst_eff     = instance_select_capability ?
		sel_inst[bw_cfg_pkg::INST_W-1:0] : '0;
	assign inst_ok      = !instance_select_capability ||
		(sel_inst < bw_cfg_pkg::NUM_INST);
	// a selector naming no stored entry reaches nothing
	assign sel_ok       = (sel_part < bw_cfg_pkg::NUM_PART) && inst_ok &&
		(sel_internal == narrowing_implemented);
	assign min_present  = feature_present && bw_partitioning_flag &&
		min_capability_flag;
	assign pbm_present  = feature_present && bw_partitioning_flag &&
		bitmap_capability_flag;
	assign is_min       = (reg_addr == bw_cfg_pkg::MIN_OFFSET);
	assign is_pbm       = (reg_addr >= bw_cfg_pkg::PBM_BASE) &&
		(reg_addr <= bw_cfg_pkg::PBM_LAST) &&
		(reg_addr[bw_cfg_pkg::WORD_LSB-1:0] == '0);
	assign min_idx      = {reg_secure, inst_eff,
		sel_part[bw_cfg_pkg::PART_W-1:0]};
	assign word_n       = reg_addr[bw_cfg_pkg::WORD_LSB +:
		bw_cfg_pkg::WORD_IDX_W];
	assign pbm_idx      = {min_idx, word_n};
	assign fmask        = frac_mask(alloc_fraction_width);
	assign wmask        = word_mask(word_n, portion_bitmap_width);
	assign pbm_wr       = reg_req && reg_we && is_pbm && pbm_present &&
		sel_ok;
	assign lk_idx       = {lk_secure, lk_instance, lk_partition,
		lk_portion[bw_cfg_pkg::PORTION_W-1:bw_cfg_pkg::BIT_IDX_W]};
	assign lk_mask      = word_mask(
		lk_portion[bw_cfg_pkg::PORTION_W-1:bw_cfg_pkg::BIT_IDX_W],
		portion_bitmap_width);

	bw_bitmap_store u_store (
		.clk_sys (clk_sys),
		.wr_en   (pbm_wr),
		.wr_idx  (pbm_idx),
		.wr_data (reg_wdata & wmask),
		.rd_idx  (pbm_idx),
		.rd_data (pbm_rd),
		.lk_idx  (lk_idx),
		.lk_data (lk_word)
	);

	genvar g;
	generate
		for (g = 0; g < bw_cfg_pkg::NUM_PART; g++) begin : g_min
			assign arb_min[g*bw_cfg_pkg::FRAC_W +: bw_cfg_pkg::FRAC_W] =
				min_present ? (st_q.min[{arb_secure, arb_instance,
				bw_cfg_pkg::PART_W'(g)}] & fmask) : '0;
		end
	endgenerate

	bw_min_arbiter u_arb (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.req     (arb_req),
		.usage   (arb_usage),
		.minv    (arb_min),
		.grant   (arb_grant)
	);

	always_comb begin
		st_d       = st_q;
		st_d.ack   = reg_req;
		st_d.rdata = bw_cfg_pkg::WORD_ZERO;
		// permission of one portion for the lookup port
		st_d.allowed = pbm_present &&
			lk_word[lk_portion[bw_cfg_pkg::BIT_IDX_W-1:0]] &&
			lk_mask[lk_portion[bw_cfg_pkg::BIT_IDX_W-1:0]];
		if (reg_req && sel_ok) begin
			if (is_min && min_present) begin
				if (reg_we) begin
					st_d.min[min_idx] =
						reg_wdata[bw_cfg_pkg::FRAC_W-1:0] & fmask;
				end else begin
					st_d.rdata = {bw_cfg_pkg::RSVD_ZERO,
						st_q.min[min_idx] & fmask};
				end
			end else if (is_pbm && pbm_present && !reg_we) begin
				st_d.rdata = pbm_rd & wmask;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign reg_ack    = st_q.ack;
	assign reg_rdata  = st_q.rdata;
	assign lk_allowed = st_q.allowed;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence min_write_s;
		reg_req && reg_we && is_min && min_present && sel_ok;
	endsequence

	sequence min_read_same_s;
		reg_req && !reg_we && is_min && min_present && sel_ok &&
		$stable(min_idx) && $stable(fmask);
	endsequence

	req_ack_a: assert property (reg_req |=> reg_ack)
		else $error("register request not answered next cycle");

	min_readback_a: assert property (min_write_s ##1 min_read_same_s |=>
		reg_rdata == {bw_cfg_pkg::RSVD_ZERO,
		$past(reg_wdata[bw_cfg_pkg::FRAC_W-1:0], 2) & $past(fmask)})
		else $error("minimum read back differs from last write");

	min_reserved_a: assert property (reg_req && !reg_we && is_min |=>
		reg_rdata[bw_cfg_pkg::DATA_W-1:bw_cfg_pkg::FRAC_W] == '0)
		else $error("minimum upper bits not zero");

	min_unimpl_a: assert property (reg_req && !reg_we && is_min |=>
		(reg_rdata[bw_cfg_pkg::FRAC_W-1:0] & ~$past(fmask)) == '0)
		else $error("unimplemented fraction bits not zero");

	min_absent_a: assert property (reg_req && is_min && !min_present |=>
		reg_rdata == '0 && $stable(st_q.min))
		else $error("absent minimum register not read-zero write-ignore");

	pbm_absent_a: assert property (reg_req && is_pbm && !pbm_present |->
		!pbm_wr ##1 reg_rdata == '0)
		else $error("absent bitmap not read-zero write-ignore");

	pbm_reserved_a: assert property (reg_req && !reg_we && is_pbm |=>
		(reg_rdata & ~$past(wmask)) == '0)
		else $error("bitmap bits beyond width not zero");

	space_split_a: assert property (reg_req && reg_secure |=>
		$stable(st_q.min[bw_cfg_pkg::NUM_MIN/2-1:0]))
		else $error("secure access changed a non-secure setting");

	internal_flag_a: assert property (reg_req &&
		(sel_internal != narrowing_implemented) |=>
		reg_rdata == '0 && $stable(st_q.min))
		else $error("mismatched internal flag reached a setting");

	unmapped_a: assert property (reg_req && !is_min && !is_pbm |=>
		reg_rdata == '0)
		else $error("unmapped offset returned data");

	lookup_bit_a: assert property (!pbm_present |=> !lk_allowed)
		else $error("portion allowed without bitmap present");

	sequence refused_s;
		reg_req && !sel_ok;
	endsequence

	sequence min_read_s;
		reg_req && !reg_we && is_min && min_present && sel_ok;
	endsequence

	ack_pulse_a: assert property (!reg_req |=> !reg_ack)
		else $error("answer without a request");

	idle_rdata_a: assert property (!reg_req |=> reg_rdata == '0)
		else $error("read data not zero while idle");

	write_rdata_a: assert property (reg_req && reg_we |=>
		reg_rdata == '0)
		else $error("write answered with nonzero data");

	refused_sel_a: assert property (refused_s |=>
		reg_rdata == '0 && $stable(st_q.min))
		else $error("unselectable entry reached a setting");

	min_write_a: assert property (min_write_s |=>
		st_q.min[$past(min_idx)] ==
		($past(reg_wdata[bw_cfg_pkg::FRAC_W-1:0]) &
		$past(fmask)))
		else $error("minimum write not stored masked");

	min_field_a: assert property (min_read_s |=>
		reg_rdata[bw_cfg_pkg::FRAC_W-1:0] ==
		($past(st_q.min[min_idx]) & $past(fmask)))
		else $error("minimum read differs from stored value");

	min_keep_a: assert property (reg_req && !(reg_we && is_min) |=>
		$stable(st_q.min))
		else $error("minimum changed without a write to it");

	ns_split_a: assert property (reg_req && !reg_secure |=>
		$stable(st_q.min[bw_cfg_pkg::NUM_MIN-1:
		bw_cfg_pkg::NUM_MIN/2]))
		else $error("non-secure access changed a secure setting");

	lookup_beyond_a: assert property (
		!lk_mask[lk_portion[bw_cfg_pkg::BIT_IDX_W-1:0]] |=>
		!lk_allowed)
		else $error("portion beyond bitmap width allowed");

	grant_idle_a: assert property (arb_req == '0 |=>
		arb_grant == '0)
		else $error("grant without a request");

	grant_subset_a: assert property (|arb_grant |->
		(arb_grant & $past(arb_req)) != '0)
		else $error("grant to a partition that did not request");

	unmapped_keep_a: assert property (reg_req && !is_min && !is_pbm |=>
		$stable(st_q.min))
		else $error("unmapped access changed a setting");
endmodule : bw_min_portion_partition_cfg

// >>> tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic        clk_sys = 1'b0;
	logic        rst_n   = 1'b0;
	logic        reg_req = 1'b0;
	logic        reg_we  = 1'b0;
	logic        reg_secure = 1'b0;
	logic [15:0] reg_addr  = 16'h0000;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic        reg_ack;
	logic [31:0] reg_rdata;
	logic [15:0] sp_s = 16'h0000, sp_ns = 16'h0000;
	logic [3:0]  si_s = 4'h0, si_ns = 4'h0;
	logic        sn_s = 1'b0, sn_ns = 1'b0;
	logic        feat = 1'b1, part_f = 1'b1, min_f = 1'b1, pbm_f = 1'b1;
	logic        inst_cap = 1'b1, nrw_f = 1'b0;
	logic        lk_inst = 1'b0, arb_inst = 1'b0;
	logic [5:0]  frac_wd = 6'h10;
	logic [12:0] pbm_wd = 13'h0028;
	logic        arb_secure = 1'b0;
	logic [3:0]  arb_req = 4'h0;
	logic [63:0] arb_usage = 64'h0;
	logic [3:0]  arb_grant;
	logic        lk_secure = 1'b0;
	logic [1:0]  lk_partition = 2'h0;
	logic [11:0] lk_portion = 12'h000;
	logic        lk_allowed;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          cyc = 0;
	localparam logic [15:0] MIN = bw_cfg_pkg::MIN_OFFSET;
	localparam logic [15:0] PB  = bw_cfg_pkg::PBM_BASE;

	bw_min_portion_partition_cfg uut (
		.clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req),
		.reg_we(reg_we), .reg_secure(reg_secure), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
		.sel_part_s(sp_s), .sel_inst_s(si_s), .sel_internal_s(sn_s),
		.sel_part_ns(sp_ns), .sel_inst_ns(si_ns), .sel_internal_ns(sn_ns),
		.feature_present(feat), .bw_partitioning_flag(part_f),
		.min_capability_flag(min_f), .bitmap_capability_flag(pbm_f),
		.instance_select_capability(inst_cap),
		.narrowing_implemented(nrw_f),
		.alloc_fraction_width(frac_wd), .portion_bitmap_width(pbm_wd),
		.arb_secure(arb_secure), .arb_instance(arb_inst),
		.arb_req(arb_req),
		.arb_usage(arb_usage), .arb_grant(arb_grant),
		.lk_secure(lk_secure), .lk_instance(lk_inst),
		.lk_partition(lk_partition), .lk_portion(lk_portion),
		.lk_allowed(lk_allowed)
	);

	always #50 clk_sys = ~clk_sys;

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt = error_cnt + 1;
			finish_test();
		end
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			error_cnt = error_cnt + 1;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// one access; answer is looked at in the single cycle it stands
	task automatic acc(input logic we, input logic s, input logic [15:0] a,
			input logic [31:0] d, input logic [31:0] exp);
		@(posedge clk_sys);
		#1;
		reg_req = 1'b1;
		reg_we = we;
		reg_secure = s;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk_sys);
		#1;
		reg_req = 1'b0;
		check({31'h0, reg_ack}, 32'h0000_0001);
		check(reg_rdata, we ? 32'h0000_0000 : exp);
	endtask : acc

	// write, then read in the next cycle with the request held high
	task automatic wr_rd(input logic s, input logic [15:0] a,
			input logic [31:0] d, input logic [31:0] exp);
		@(posedge clk_sys);
		#1;
		reg_req = 1'b1;
		reg_we = 1'b1;
		reg_secure = s;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk_sys);
		#1;
		check({31'h0, reg_ack}, 32'h0000_0001);
		check(reg_rdata, 32'h0000_0000);
		reg_we = 1'b0;
		@(posedge clk_sys);
		#1;
		reg_req = 1'b0;
		check({31'h0, reg_ack}, 32'h0000_0001);
		check(reg_rdata, exp);
	endtask : wr_rd

	task automatic sel(input logic s, input logic [15:0] p,
			input logic [3:0] i, input logic n);
		if (s) begin
			sp_s = p;
			si_s = i;
			sn_s = n;
		end else begin
			sp_ns = p;
			si_ns = i;
			sn_ns = n;
		end
	endtask : sel

	task automatic lk(input logic s, input logic [11:0] p, input logic exp);
		@(posedge clk_sys);
		#1;
		lk_secure = s;
		lk_portion = p;
		@(posedge clk_sys);
		#1;
		check({31'h0, lk_allowed}, {31'h0, exp});
	endtask : lk

	task automatic arb(input logic s, input logic [3:0] rq,
			input logic [63:0] u, input logic [3:0] exp);
		@(posedge clk_sys);
		#1;
		arb_secure = s;
		arb_req = rq;
		arb_usage = u;
		@(posedge clk_sys);
		#1;
		check({28'h0, arb_grant}, {28'h0, exp});
	endtask : arb

	task automatic finish_test();
		if (error_cnt == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test

	initial begin
		repeat (3) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		acc(0, 0, MIN, 0, 32'h0000_0000);
		acc(1, 0, MIN, 32'hABCD_1234, 0);
		acc(0, 0, MIN, 0, 32'h0000_1234);
		acc(1, 1, MIN, 32'h0000_5678, 0);
		acc(0, 1, MIN, 0, 32'h0000_5678);
		acc(0, 0, MIN, 0, 32'h0000_1234);
		sel(0, 0, 1, 0);
		acc(1, 0, MIN, 32'h0000_1111, 0);
		acc(0, 0, MIN, 0, 32'h0000_1111);
		inst_cap = 1'b0;
		acc(0, 0, MIN, 0, 32'h0000_1234);
		inst_cap = 1'b1;
		sel(0, 0, 0, 0);
		acc(0, 0, MIN, 0, 32'h0000_1234);
		// only the top four fraction bits are kept
		frac_wd = 6'h04;
		sel(0, 1, 0, 0);
		acc(1, 0, MIN, 32'h0000_FFFF, 0);
		acc(0, 0, MIN, 0, 32'h0000_F000);
		frac_wd = 6'h10;
		// instance 1 partition 3 gets a minimum that instance 0 lacks
		sel(0, 3, 1, 0);
		wr_rd(0, MIN, 32'h0000_4000, 32'h0000_4000);
		arb_inst = 1'b1;
		arb(0, 4'h9, 64'h2000_0000_0000_FFFF, 4'h8);
		arb_inst = 1'b0;
		arb(0, 4'h9, 64'h2000_0000_0000_FFFF, 4'h1);
		sel(0, 2, 0, 0);
		acc(1, 0, MIN, 32'h0000_8000, 0);
		// usage just under and exactly at the minimum of partition 2
		arb(0, 4'hF, 64'h0000_7FFF_FFFF_FFFF, 4'h4);
		arb(0, 4'hF, 64'h0000_8000_FFFF_FFFF, 4'h1);
		arb(0, 4'h8, 64'h0, 4'h8);
		arb(0, 4'h0, 64'h0, 4'h0);
		arb(1, 4'h3, 64'h0000_0000_0000_6000, 4'h1);
		arb(0, 4'h3, 64'h0000_0000_0000_6000, 4'h2);
		sel(0, 0, 0, 1);
		acc(1, 0, MIN, 32'h0000_9999, 0);
		acc(0, 0, MIN, 0, 32'h0000_0000);
		nrw_f = 1'b1;
		sel(0, 0, 0, 0);
		acc(0, 0, MIN, 0, 32'h0000_0000);
		nrw_f = 1'b0;
		acc(0, 0, MIN, 0, 32'h0000_1234);
		acc(0, 0, 16'h0204, 0, 32'h0000_0000);
		// out-of-range partition and instance reach nothing
		sel(0, 16'h0004, 0, 0);
		acc(1, 0, MIN, 32'h0000_7777, 0);
		acc(0, 0, MIN, 0, 32'h0000_0000);
		sel(0, 0, 2, 0);
		acc(0, 0, MIN, 0, 32'h0000_0000);
		sel(0, 0, 0, 0);
		acc(0, 0, MIN, 0, 32'h0000_1234);
		min_f = 1'b0;
		acc(1, 0, MIN, 32'h0000_4444, 0);
		acc(0, 0, MIN, 0, 32'h0000_0000);
		min_f = 1'b1;
		feat = 1'b0;
		acc(0, 0, MIN, 0, 32'h0000_0000);
		feat = 1'b1;
		acc(0, 0, MIN, 0, 32'h0000_1234);
		sel(0, 0, 0, 0);
		acc(1, 0, PB, 32'h0000_0005, 0);
		acc(0, 0, PB, 0, 32'h0000_0005);
		acc(1, 0, PB + 16'h0004, 32'hFFFF_FFFF, 0);
		acc(0, 0, PB + 16'h0004, 0, 32'h0000_00FF);
		acc(1, 0, PB + 16'h0008, 32'hFFFF_FFFF, 0);
		acc(0, 0, PB + 16'h0008, 0, 32'h0000_0000);
		lk(0, 12'h000, 1'b1);
		lk(0, 12'h001, 1'b0);
		lk(0, 12'h002, 1'b1);
		lk(0, 12'h021, 1'b1);
		lk(0, 12'h027, 1'b1);
		lk(0, 12'h028, 1'b0);
		sel(0, 1, 1, 0);
		acc(1, 0, PB, 32'h0000_0010, 0);
		lk_inst = 1'b1;
		lk_partition = 2'h1;
		lk(0, 12'h004, 1'b1);
		lk(0, 12'h000, 1'b0);
		lk_inst = 1'b0;
		lk_partition = 2'h0;
		sel(0, 0, 0, 0);
		pbm_wd = 13'h1000;
		acc(1, 0, 16'h21FC, 32'hFFFF_FFFF, 0);
		acc(0, 0, 16'h21FC, 0, 32'hFFFF_FFFF);
		lk(0, 12'hFFF, 1'b1);
		sel(1, 0, 0, 0);
		acc(1, 1, PB, 32'h0000_0002, 0);
		acc(0, 1, PB, 0, 32'h0000_0002);
		acc(0, 0, PB, 0, 32'h0000_0005);
		lk(1, 12'h001, 1'b1);
		lk(1, 12'h000, 1'b0);
		pbm_f = 1'b0;
		acc(1, 0, PB, 32'hFFFF_FFFF, 0);
		acc(0, 0, PB, 0, 32'h0000_0000);
		lk(0, 12'h000, 1'b0);
		pbm_f = 1'b1;
		part_f = 1'b0;
		acc(0, 0, PB, 0, 32'h0000_0000);
		part_f = 1'b1;
		acc(0, 0, PB, 0, 32'h0000_0005);
		finish_test();
	end
endmodule : tb_top
